// ==== logic/ppsc_power_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - force-float bit keeps common electrode floating
// - common priority: force-float, ground, float-when-off
// - ground-on-refresh grounds common outside refresh
// - display off: float or power-off level
// - power command bit0 selects internal gate supply
// - bit1 selects internal source supply
// - two-bit gate rail level, 20 to 17V
// - bit7 extends gate code to 16/15V
// - bit2 selects common swing source or gate
// - source positive level from 6.4V, 0.2V steps
// - source negative level from -6.4V, 0.2V steps
// - red level, coarse or fine step mode
// - power-off command runs the power-off sequence
// - busy low during power-off, then high
// - power-off disables analogue blocks, keeps registers
// - outputs end at zero volts or floating
// - power-off accepted only while not busy
module ppsc_power_ctrl
	import ppsc_pkg::*;
(
	input  wire logic           clock_in,
	input  wire logic           rst_n_in,
	input  wire logic           link_clk_in,
	input  wire logic           csb_n_in,
	input  wire logic           sda_in,
	input  wire logic           dc_in,
	input  wire logic           power_on_in,
	input  wire logic           display_on_in,
	input  wire logic           refreshing_in,
	output var  logic           busy_n_out,
	output var  logic           gate_supply_internal_out,
	output var  logic           source_supply_internal_out,
	output var  logic [2:0]     gate_rail_level_out,
	output var  logic [4:0]     gate_rail_volts_out,
	output var  logic           common_swing_select_out,
	output var  logic [7:0]     source_pos_tenths_out,
	output var  logic [7:0]     source_neg_tenths_out,
	output var  logic           fine_step_enable_out,
	output var  logic [8:0]     red_pos_tenths_out,
	output var  ppsc_enables_t  enables_out,
	output var  ppsc_out_mode_t common_mode_out,
	output var  ppsc_out_mode_t source_mode_out
);

	// whole block state in one packed struct
	typedef struct packed {
		ppsc_cur_cmd_t   cur;          // command owning the data bytes
		logic [2:0]      param_idx;    // next parameter slot
		ppsc_power_cfg_t cfg;          // stored power configuration
		logic            force_float;  // panel config second byte bits
		logic            gnd_refresh;
		logic            float_off;
		ppsc_seq_t       seq;          // power-off sequence state
		logic [7:0]      seq_cnt;      // stage timer
		logic            busy_n;       // idle flag shown on the pin
		logic            rails_up;     // panel powered
		ppsc_enables_t   en;           // analogue enables
		logic            seen_tog;     // last accepted byte toggle
		logic [2:0]      gate_code;    // decoded outputs
		logic [4:0]      gate_volts;
		logic [7:0]      src_pos;
		logic [7:0]      src_neg;
		logic [8:0]      red_pos;
		ppsc_out_mode_t  com_mode;
		ppsc_out_mode_t  src_mode;
	} ppsc_state_t;

	ppsc_state_t st_q;
	ppsc_state_t st_d;

	ppsc_byte_t  rx_byte;     // held byte from the link domain
	logic        rx_tog;      // byte event toggle, link domain
	logic        tog_s2;      // synchronised toggle stages
	logic        tog_s3;

	// byte framing on the link's own clock
	ppsc_link_rx u_link_rx (
		.link_clk_in     (link_clk_in),
		.rst_n_in        (rst_n_in),
		.csb_n_in        (csb_n_in),
		.sda_in          (sda_in),
		.dc_in           (dc_in),
		.byte_out        (rx_byte),
		.byte_toggle_out (rx_tog)
	);

	// toggle crossing; the byte itself stays still for eight link clocks
	ppsc_sync #(
		.WIDTH (1)
	) u_tog_sync (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.async_in   (rx_tog),
		.stage2_out (tog_s2),
		.stage3_out (tog_s3)
	);

	// reset image of the whole state
	function automatic ppsc_state_t reset_state();
		ppsc_state_t r;
		r              = '0;
		r.cfg.supply   = PPSC_SUPPLY_RST;
		r.cfg.gate_com = PPSC_GATE_COM_RST;
		r.cfg.src_pos  = PPSC_SRC_POS_RST;
		r.cfg.src_neg  = PPSC_SRC_NEG_RST;
		r.cfg.red_pos  = PPSC_RED_POS_RST;
		r.force_float  = PPSC_PANEL2_RST[PPSC_FORCE_FLT_BIT];
		r.gnd_refresh  = PPSC_PANEL2_RST[PPSC_GND_REFR_BIT];
		r.float_off    = PPSC_PANEL2_RST[PPSC_FLOAT_OFF_BIT];
		r.seq          = PPSC_SEQ_IDLE;
		r.busy_n       = 1'b1;
		r.gate_volts   = PPSC_GATE_TOP_V;
		// reset codes lie above the table top, so the decoded levels show clamped
		r.src_pos      = PPSC_SRC_BASE_TENTHS + {1'b0, PPSC_SRC_CODE_MAX, 1'b0};
		r.src_neg      = PPSC_SRC_BASE_TENTHS + {1'b0, PPSC_SRC_CODE_MAX, 1'b0};
		r.red_pos      = PPSC_RED_BASE_TENTHS + {1'b0, PPSC_RED_POS_RST[6:0], 1'b0};
		r.com_mode     = PPSC_OUT_FLOAT;
		r.src_mode     = PPSC_OUT_FLOAT;
		return r;
	endfunction

	// next-state logic
	always_comb begin
		logic           got_byte;   // a new byte crossed over
		logic           off_take;   // power-off accepted this cycle
		logic           disp_act;   // display considered on
		logic [2:0]     code;       // raw three-bit gate code
		logic [5:0]     pos_code;   // clamped source positive code
		logic [5:0]     neg_code;   // clamped source negative code
		ppsc_out_mode_t off_mode;
		got_byte = 1'b0;
		off_take = 1'b0;
		disp_act = 1'b0;
		code     = 3'h0;
		pos_code = 6'h00;
		neg_code = 6'h00;
		off_mode = PPSC_OUT_FLOAT;
		st_d     = st_q;

		// a change counts once stages two and three agree
		if ((tog_s2 == tog_s3) && (tog_s3 != st_q.seen_tog)) begin
			got_byte      = 1'b1;
			st_d.seen_tog = tog_s3;
		end

		// byte decode: command bytes start a command, data bytes fill slots
		if (got_byte) begin
			if (!rx_byte.is_data) begin
				st_d.param_idx = 3'h0;
				case (rx_byte.value)
					PPSC_CMD_POWER_CONFIG: begin
						st_d.cur = PPSC_CUR_POWER;
					end
					PPSC_CMD_PANEL_CONFIG: begin
						st_d.cur = PPSC_CUR_PANEL;
					end
					PPSC_CMD_POWER_OFF: begin
						// no parameters; ignored while the sequence is running
						st_d.cur = PPSC_CUR_NONE;
						off_take = st_q.busy_n && (st_q.seq == PPSC_SEQ_IDLE);
					end
					default: begin
						// commands handled elsewhere release the parameter slots
						st_d.cur = PPSC_CUR_NONE;
					end
				endcase
			end else begin
				// a short list only changes the slots it reached
				case (st_q.cur)
					PPSC_CUR_POWER: begin
						case (st_q.param_idx)
							3'h0: st_d.cfg.supply = rx_byte.value;
							3'h1: st_d.cfg.gate_com = rx_byte.value;
							3'h2: st_d.cfg.src_pos = rx_byte.value;
							3'h3: st_d.cfg.src_neg = rx_byte.value;
							3'h4: st_d.cfg.red_pos = rx_byte.value;
							default: begin
								// surplus bytes are dropped
								st_d.cfg = st_q.cfg;
							end
						endcase
						if (st_q.param_idx < PPSC_POWER_PARAMS) begin
							st_d.param_idx = st_q.param_idx + 3'h1;
						end
					end
					PPSC_CUR_PANEL: begin
						// first byte belongs to other panel settings
						if (st_q.param_idx == 3'h1) begin
							st_d.force_float = rx_byte.value[PPSC_FORCE_FLT_BIT];
							st_d.gnd_refresh = rx_byte.value[PPSC_GND_REFR_BIT];
							st_d.float_off   = rx_byte.value[PPSC_FLOAT_OFF_BIT];
						end
						if (st_q.param_idx < PPSC_PANEL_PARAMS) begin
							st_d.param_idx = st_q.param_idx + 3'h1;
						end
					end
					default: begin
						// stray data with no owning command
						st_d.param_idx = st_q.param_idx;
					end
				endcase
			end
		end

		// power-up request from the power-on sequencer, only when idle
		if (power_on_in && st_q.busy_n && (st_q.seq == PPSC_SEQ_IDLE) && !off_take) begin
			st_d.rails_up = 1'b1;
			st_d.en       = '1;
		end

		// power-off sequence; registers are left alone
		case (st_q.seq)
			PPSC_SEQ_IDLE: begin
				if (off_take) begin
					st_d.busy_n  = 1'b0;
					st_d.seq     = PPSC_SEQ_DRV_OFF;
					st_d.seq_cnt = '0;
				end
			end
			PPSC_SEQ_DRV_OFF: begin
				// drivers, tcon and sensor go first, pump keeps rails meanwhile
				st_d.en.tcon        = 1'b0;
				st_d.en.source_drv  = 1'b0;
				st_d.en.gate_drv    = 1'b0;
				st_d.en.common_drv  = 1'b0;
				st_d.en.temp_sensor = 1'b0;
				st_d.rails_up       = 1'b0;
				st_d.seq_cnt        = st_q.seq_cnt + 8'h01;
				if (st_q.seq_cnt == PPSC_OFF_STAGE_LAST) begin
					st_d.seq     = PPSC_SEQ_PUMP_OFF;
					st_d.seq_cnt = '0;
				end
			end
			PPSC_SEQ_PUMP_OFF: begin
				st_d.en.charge_pump = 1'b0;
				st_d.seq_cnt        = st_q.seq_cnt + 8'h01;
				if (st_q.seq_cnt == PPSC_OFF_STAGE_LAST) begin
					st_d.seq = PPSC_SEQ_FINISH;
				end
			end
			PPSC_SEQ_FINISH: begin
				st_d.busy_n  = 1'b1;
				st_d.seq     = PPSC_SEQ_IDLE;
				st_d.seq_cnt = '0;
			end
			default: begin
				// unknown encoding falls back to idle
				st_d.seq    = PPSC_SEQ_IDLE;
				st_d.busy_n = 1'b1;
			end
		endcase

		// gate rail code: bit7 adds a third bit, unused codes clamp to 15V
		code = {st_d.cfg.gate_com[PPSC_GATE_EXT_BIT], st_d.cfg.gate_com[1:0]};
		if (code > PPSC_GATE_CODE_MAX) begin
			code = PPSC_GATE_CODE_MAX;
		end
		st_d.gate_code  = code;
		st_d.gate_volts = PPSC_GATE_TOP_V - {2'b00, code};

		// source levels; codes above the table clamp to its top
		pos_code = st_d.cfg.src_pos[5:0];
		neg_code = st_d.cfg.src_neg[5:0];
		if (pos_code > PPSC_SRC_CODE_MAX) begin
			pos_code = PPSC_SRC_CODE_MAX;
		end
		if (neg_code > PPSC_SRC_CODE_MAX) begin
			neg_code = PPSC_SRC_CODE_MAX;
		end
		st_d.src_pos = PPSC_SRC_BASE_TENTHS + {1'b0, pos_code, 1'b0};
		st_d.src_neg = PPSC_SRC_BASE_TENTHS + {1'b0, neg_code, 1'b0};

		// red level: fine mode counts from 80h in single tenths
		if (st_d.cfg.red_pos[PPSC_FINE_BIT]) begin
			st_d.red_pos = PPSC_RED_BASE_TENTHS + {2'b00, st_d.cfg.red_pos[6:0]};
		end else begin
			st_d.red_pos = PPSC_RED_BASE_TENTHS + {1'b0, st_d.cfg.red_pos[6:0], 1'b0};
		end

		// display counts as on only with rails up and the panel enabled
		disp_act = st_d.rails_up && display_on_in;
		off_mode = st_d.float_off ? PPSC_OUT_FLOAT : PPSC_OUT_OFFLVL;

		// common electrode by priority, highest first
		if (st_d.force_float) begin
			st_d.com_mode = PPSC_OUT_FLOAT;
		end else if (st_d.gnd_refresh && !refreshing_in) begin
			st_d.com_mode = PPSC_OUT_GROUND;
		end else if (!disp_act) begin
			st_d.com_mode = off_mode;
		end else begin
			st_d.com_mode = PPSC_OUT_DRIVE;
		end

		// source outputs end as configured once powered down
		st_d.src_mode = disp_act ? PPSC_OUT_DRIVE : off_mode;
	end

	// single state register; reset restores every default
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= reset_state();
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state flops
	assign busy_n_out                 = st_q.busy_n;
	assign gate_supply_internal_out   = st_q.cfg.supply[PPSC_GATE_INT_BIT];
	assign source_supply_internal_out = st_q.cfg.supply[PPSC_SRC_INT_BIT];
	assign gate_rail_level_out        = st_q.gate_code;
	assign gate_rail_volts_out        = st_q.gate_volts;
	assign common_swing_select_out    = st_q.cfg.gate_com[PPSC_SWING_BIT];
	assign source_pos_tenths_out      = st_q.src_pos;
	assign source_neg_tenths_out      = st_q.src_neg;
	assign fine_step_enable_out       = st_q.cfg.red_pos[PPSC_FINE_BIT];
	assign red_pos_tenths_out         = st_q.red_pos;
	assign enables_out                = st_q.en;
	assign common_mode_out            = st_q.com_mode;
	assign source_mode_out            = st_q.src_mode;

endmodule
`default_nettype wire

// ==== logic/ppsc_pkg.sv ====
package ppsc_pkg;

	// command codes seen with the command/data select low
	localparam logic [7:0] PPSC_CMD_PANEL_CONFIG = 8'h00;
	localparam logic [7:0] PPSC_CMD_POWER_CONFIG = 8'h01;
	localparam logic [7:0] PPSC_CMD_POWER_OFF    = 8'h02;

	// parameter counts of the commands this block owns
	localparam logic [2:0] PPSC_POWER_PARAMS = 3'h5;
	localparam logic [2:0] PPSC_PANEL_PARAMS = 3'h2;

	// reset values of the power configuration bytes
	localparam logic [7:0] PPSC_SUPPLY_RST    = 8'h03;
	localparam logic [7:0] PPSC_GATE_COM_RST  = 8'h00;
	localparam logic [7:0] PPSC_SRC_POS_RST   = 8'h26;
	localparam logic [7:0] PPSC_SRC_NEG_RST   = 8'h26;
	localparam logic [7:0] PPSC_RED_POS_RST   = 8'h06;
	// reset value of the panel configuration second byte
	localparam logic [7:0] PPSC_PANEL2_RST    = 8'h09;

	// field positions
	localparam int PPSC_GATE_INT_BIT   = 0;
	localparam int PPSC_SRC_INT_BIT    = 1;
	localparam int PPSC_SWING_BIT      = 2;
	localparam int PPSC_GATE_EXT_BIT   = 7;
	localparam int PPSC_FINE_BIT       = 7;
	localparam int PPSC_FLOAT_OFF_BIT  = 0;
	localparam int PPSC_GND_REFR_BIT   = 1;
	localparam int PPSC_FORCE_FLT_BIT  = 4;

	// level decode, gate rail in volts, source and red levels in tenths of a volt
	localparam logic [4:0] PPSC_GATE_TOP_V       = 5'h14;
	localparam logic [2:0] PPSC_GATE_CODE_MAX    = 3'h5;
	localparam logic [7:0] PPSC_SRC_BASE_TENTHS  = 8'h40;
	localparam logic [8:0] PPSC_RED_BASE_TENTHS  = 9'h018;
	localparam logic [5:0] PPSC_SRC_CODE_MAX     = 6'h1f;

	// power-off stage time, least time rounded up to whole cycles
	localparam int PPSC_CLK_PERIOD_NS   = 25;
	localparam int PPSC_OFF_STAGE_NS    = 2000;
	localparam int PPSC_OFF_STAGE_CYC   = (PPSC_OFF_STAGE_NS + PPSC_CLK_PERIOD_NS - 1) / PPSC_CLK_PERIOD_NS;
	localparam logic [7:0] PPSC_OFF_STAGE_LAST = 8'(PPSC_OFF_STAGE_CYC - 1);

	// one received byte and its command/data qualifier
	typedef struct packed {
		logic       is_data;
		logic [7:0] value;
	} ppsc_byte_t;

	// stored power configuration bytes
	typedef struct packed {
		logic [7:0] supply;
		logic [7:0] gate_com;
		logic [7:0] src_pos;
		logic [7:0] src_neg;
		logic [7:0] red_pos;
	} ppsc_power_cfg_t;

	// analogue block enables
	typedef struct packed {
		logic charge_pump;
		logic tcon;
		logic source_drv;
		logic gate_drv;
		logic common_drv;
		logic temp_sensor;
	} ppsc_enables_t;

	// common electrode / source output condition
	typedef enum logic [1:0] {
		PPSC_OUT_DRIVE  = 2'h0,
		PPSC_OUT_FLOAT  = 2'h1,
		PPSC_OUT_GROUND = 2'h2,
		PPSC_OUT_OFFLVL = 2'h3
	} ppsc_out_mode_t;

	// command in progress for parameter bytes
	typedef enum logic [1:0] {
		PPSC_CUR_NONE  = 2'h0,
		PPSC_CUR_POWER = 2'h1,
		PPSC_CUR_PANEL = 2'h2
	} ppsc_cur_cmd_t;

	// power-off sequence, gray along the path
	typedef enum logic [1:0] {
		PPSC_SEQ_IDLE     = 2'b00,
		PPSC_SEQ_DRV_OFF  = 2'b01,
		PPSC_SEQ_PUMP_OFF = 2'b11,
		PPSC_SEQ_FINISH   = 2'b10
	} ppsc_seq_t;

endpackage

// ==== logic/ppsc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; stage one feeds only stage two
module ppsc_sync
	import ppsc_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] stage2_out,
	output var  logic [WIDTH-1:0] stage3_out
);

	// all stages in one packed state
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
	} ppsc_sync_state_t;

	ppsc_sync_state_t st_q;
	ppsc_sync_state_t st_d;

	// shift one stage per edge
	always_comb begin
		st_d    = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	// register, cleared to zero
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign stage2_out = st_q.s2;
	assign stage3_out = st_q.s3;

endmodule
`default_nettype wire

// ==== logic/ppsc_link_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
// serial byte receiver on the link clock; msb first, 4-wire mode
module ppsc_link_rx
	import ppsc_pkg::*;
(
	input  wire logic       link_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       csb_n_in,
	input  wire logic       sda_in,
	input  wire logic       dc_in,
	output var  ppsc_byte_t byte_out,
	output var  logic       byte_toggle_out
);

	// bit framing, cleared whenever the chip select is high
	typedef struct packed {
		logic [6:0] shift;
		logic [2:0] count;
	} ppsc_frame_t;

	// finished byte and its event toggle, kept across frames
	typedef struct packed {
		ppsc_byte_t word;
		logic       toggle;
	} ppsc_word_t;

	ppsc_frame_t fr_q;
	ppsc_frame_t fr_d;
	ppsc_word_t  wd_q;
	ppsc_word_t  wd_d;
	logic        frame_clr_n;

	// the link clock stops between frames, so csb clears the framing without it
	assign frame_clr_n = rst_n_in & ~csb_n_in;

	// shift in a bit; the eighth bit completes a byte
	always_comb begin
		fr_d = fr_q;
		wd_d = wd_q;
		if (fr_q.count == 3'h7) begin
			wd_d.word.value   = {fr_q.shift, sda_in};
			wd_d.word.is_data = dc_in;
			wd_d.toggle       = ~wd_q.toggle;
			fr_d.count        = 3'h0;
		end else begin
			fr_d.shift = {fr_q.shift[5:0], sda_in};
			fr_d.count = fr_q.count + 3'h1;
		end
	end

	// framing register
	always_ff @(posedge link_clk_in or negedge frame_clr_n) begin
		if (!frame_clr_n) begin
			fr_q <= '0;
		end else begin
			fr_q <= fr_d;
		end
	end

	// word register; held still until the next byte ends
	always_ff @(posedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wd_q <= '0;
		end else begin
			wd_q <= wd_d;
		end
	end

	assign byte_out        = wd_q.word;
	assign byte_toggle_out = wd_q.toggle;

endmodule
`default_nettype wire

// ==== bench/ppsc_power_ctrl_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the power configuration block, system clock only
module ppsc_power_ctrl_assertions
	import ppsc_pkg::*;
(
	input wire logic           clock_in,
	input wire logic           rst_n_in,
	input wire logic           display_on_in,
	input wire logic           refreshing_in,
	input wire logic           busy_n_out,
	input wire logic [2:0]     gate_rail_level_out,
	input wire logic [4:0]     gate_rail_volts_out,
	input wire logic [7:0]     source_pos_tenths_out,
	input wire logic [7:0]     source_neg_tenths_out,
	input wire logic           fine_step_enable_out,
	input wire logic [8:0]     red_pos_tenths_out,
	input wire ppsc_enables_t  enables_out,
	input wire ppsc_out_mode_t common_mode_out
);
	logic [8:0] busy_cnt_q; // cycles busy has been low
	logic [8:0] busy_cnt_d; // next count, saturating so it never wraps
	// count the low phase of busy
	always_comb begin
		busy_cnt_d = busy_n_out ? 9'h000 : busy_cnt_q + {8'h00, busy_cnt_q != 9'h1ff};
	end
	// async clear keeps a mid-run reset from leaving a stale count
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_cnt_q <= 9'h000;
		end else begin
			busy_cnt_q <= busy_cnt_d;
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_off_start; $fell(busy_n_out); endsequence
	sequence s_display_off; (!display_on_in) [*3]; endsequence
	property p_busy_max; busy_cnt_q <= 9'h0aa; endproperty
	property p_busy_min; $rose(busy_n_out) |-> busy_cnt_q >= 9'h09f; endproperty
	property p_drivers_off; s_off_start |-> ##[0:2] enables_out[4:0] == 5'h00; endproperty
	property p_pump_off; s_off_start |-> ##[60:100] !enables_out.charge_pump; endproperty
	property p_all_off; $rose(busy_n_out) |-> enables_out == 6'h00; endproperty
	property p_no_drive_off; s_display_off |-> common_mode_out != PPSC_OUT_DRIVE; endproperty
	property p_no_ground_refr; refreshing_in [*3] |-> common_mode_out != PPSC_OUT_GROUND; endproperty
	property p_off_common; s_off_start |-> ##[1:3] common_mode_out != PPSC_OUT_DRIVE; endproperty
	property p_gate_volts;
		gate_rail_level_out <= 3'h5 && gate_rail_volts_out == 5'h14 - {2'b00, gate_rail_level_out};
	endproperty
	property p_src_pos;
		!source_pos_tenths_out[0] && source_pos_tenths_out >= 8'h40 && source_pos_tenths_out <= 8'h7e;
	endproperty
	property p_src_neg;
		!source_neg_tenths_out[0] && source_neg_tenths_out >= 8'h40 && source_neg_tenths_out <= 8'h7e;
	endproperty
	property p_red_coarse;
		!fine_step_enable_out |-> !red_pos_tenths_out[0] && red_pos_tenths_out >= 9'h018;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy held low too long");
	a_busy_min: assert property (p_busy_min) else $error("power-off sequence too short");
	a_drivers_off: assert property (p_drivers_off) else $error("drivers still on");
	a_pump_off: assert property (p_pump_off) else $error("charge pump still on");
	a_all_off: assert property (p_all_off) else $error("enable left on after power-off");
	a_no_drive_off: assert property (p_no_drive_off) else $error("common driven with display off");
	a_no_ground_refr: assert property (p_no_ground_refr) else $error("common grounded in refresh");
	a_off_common: assert property (p_off_common) else $error("common driven after power-off");
	a_gate_volts: assert property (p_gate_volts) else $error("gate rail level mismatch");
	a_src_pos: assert property (p_src_pos) else $error("source positive level off grid");
	a_src_neg: assert property (p_src_neg) else $error("source negative level off grid");
	a_red_coarse: assert property (p_red_coarse) else $error("red level off coarse grid");
endmodule
`default_nettype wire

// ==== bench/ppsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side of the serial link; its clock runs only inside a frame
module ppsc_host_model (
	output var logic link_clk_out,
	output var logic csb_n_out,
	output var logic sda_out,
	output var logic dc_out
);
	localparam int HALF_NS = 80; // half of the 160 ns link period
	// idle frame state at time zero
	initial begin
		link_clk_out = 1'b0;
		csb_n_out = 1'b1;
		sda_out = 1'b0;
		dc_out = 1'b0;
	end
	// one byte per frame, msb first, select held across all eight bits
	task automatic send_byte(input logic is_data, input logic [7:0] value);
		#(HALF_NS / 2 + 3); // odd offset keeps the phase unrelated to clock_in
		csb_n_out = 1'b0;
		dc_out = is_data;
		for (int i = 7; i >= 0; i--) begin
			sda_out = value[i];
			#HALF_NS link_clk_out = 1'b1;
			#HALF_NS link_clk_out = 1'b0;
		end
		csb_n_out = 1'b1;
		// released lines have no pull, so show the inverse of the last value
		sda_out = ~value[0];
		dc_out = ~is_data;
	endtask
endmodule
`default_nettype wire

// ==== bench/ppsc_power_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: host model writes bytes, the block's ports are judged
module ppsc_power_ctrl_tb_top
	import ppsc_pkg::*;
;
	logic           clock_in, rst_n_in, link_clk_in, csb_n_in, sda_in, dc_in;
	logic           power_on_in, display_on_in, refreshing_in, busy_n_out;
	logic           gate_supply_internal_out, source_supply_internal_out, common_swing_select_out;
	logic [2:0]     gate_rail_level_out;
	logic [4:0]     gate_rail_volts_out;
	logic [7:0]     source_pos_tenths_out, source_neg_tenths_out;
	logic           fine_step_enable_out;
	logic [8:0]     red_pos_tenths_out;
	ppsc_enables_t  enables_out;
	ppsc_out_mode_t common_mode_out, source_mode_out;
	int             fail_count, num_checks;
	// panel bits, refreshing, display on, expected common condition
	localparam logic [11:0] COMMON_ROWS [6] = '{{8'h10, 2'b11, PPSC_OUT_FLOAT}, {8'h13, 2'b01, PPSC_OUT_FLOAT},
		{8'h03, 2'b01, PPSC_OUT_GROUND}, {8'h03, 2'b10, PPSC_OUT_FLOAT}, {8'h02, 2'b10, PPSC_OUT_OFFLVL},
		{8'h00, 2'b11, PPSC_OUT_DRIVE}};
	ppsc_power_ctrl dut (.clock_in, .rst_n_in, .link_clk_in, .csb_n_in, .sda_in, .dc_in, .power_on_in,
		.display_on_in, .refreshing_in, .busy_n_out, .gate_supply_internal_out, .source_supply_internal_out,
		.gate_rail_level_out, .gate_rail_volts_out, .common_swing_select_out, .source_pos_tenths_out,
		.source_neg_tenths_out, .fine_step_enable_out, .red_pos_tenths_out, .enables_out, .common_mode_out,
		.source_mode_out);
	ppsc_host_model host (.link_clk_out(link_clk_in), .csb_n_out(csb_n_in), .sda_out(sda_in), .dc_out(dc_in));
	// 40 MHz system clock
	always #12.5 clock_in = ~clock_in;
	// single compare, every result widened to ten bits so the fine flag is kept
	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// command byte then its parameters, then time for the crossing
	task automatic wr(input logic [7:0] cmd, input logic [7:0] prm[$]);
		host.send_byte(1'b0, cmd);
		foreach (prm[i])
			host.send_byte(1'b1, prm[i]);
		repeat (8) @(negedge clock_in);
	endtask
	// bounded wait for a busy level
	task automatic wait_busy(input logic lvl, input int lim);
		int n = 0;
		while (busy_n_out !== lvl && n < lim) begin
			@(negedge clock_in);
			n++;
		end
		chk(busy_n_out, lvl, "busy level");
	endtask
	// closing report, reached from the main flow or the watchdog
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic t_defaults();
		chk(busy_n_out, 1'b1, "busy");
		chk({gate_supply_internal_out, source_supply_internal_out}, {PPSC_SUPPLY_RST[0], PPSC_SUPPLY_RST[1]}, "supply");
		chk(gate_rail_volts_out, 9'h014, "gate volts");
		chk(common_swing_select_out, 1'b0, "swing");
		// both reset codes lie above 1fh, so the levels read at the table top
		chk(source_pos_tenths_out, 9'h040 + {PPSC_SRC_CODE_MAX, 1'b0}, "src pos");
		chk(source_neg_tenths_out, 9'h040 + {PPSC_SRC_CODE_MAX, 1'b0}, "src neg");
		chk(red_pos_tenths_out, 9'h018 + {PPSC_RED_POS_RST[6:0], 1'b0}, "red");
		chk(common_mode_out, PPSC_OUT_FLOAT, "common");
		$display("test defaults done");
	endtask
	// gate codes 0 to 5, swing toggled, later slots untouched
	task automatic t_gate_levels();
		logic [2:0] code;
		for (int c = 0; c < 6; c++) begin
			code = 3'(c);
			wr(8'h01, '{8'h03, {code[2], 4'h0, code[0], code[1:0]}});
			chk(gate_rail_level_out, code, "gate code");
			chk(gate_rail_volts_out, 9'h014 - code, "gate volts");
			chk(common_swing_select_out, code[0], "swing");
			chk(source_pos_tenths_out, 9'h07e, "src pos kept");
		end
		$display("test gate levels done");
	endtask
	// full list, fine step, then coarse step with a surplus byte
	task automatic t_full_write();
		wr(8'h01, '{8'h02, 8'h04, 8'h1f, 8'h00, 8'h80});
		chk({gate_supply_internal_out, source_supply_internal_out}, 2'b01, "supply");
		chk(source_pos_tenths_out, 9'h07e, "src pos top");
		chk(source_neg_tenths_out, 9'h040, "src neg base");
		chk({fine_step_enable_out, red_pos_tenths_out}, 10'h218, "red fine");
		wr(8'h01, '{8'h01, 8'h04, 8'h1f, 8'h00, 8'h1f, 8'hff});
		chk({gate_supply_internal_out, source_supply_internal_out}, 2'b10, "supply");
		chk({fine_step_enable_out, red_pos_tenths_out}, 10'h056, "red coarse");
		$display("test full write done");
	endtask
	// common electrode priority table
	task automatic t_common();
		power_on_in = 1'b1;
		@(negedge clock_in);
		power_on_in = 1'b0;
		foreach (COMMON_ROWS[i]) begin
			refreshing_in = COMMON_ROWS[i][3];
			display_on_in = COMMON_ROWS[i][2];
			wr(8'h00, '{8'h0f, COMMON_ROWS[i][11:4]});
			chk(common_mode_out, COMMON_ROWS[i][1:0], "common");
		end
		$display("test common done");
	endtask
	// power-off, a second request while busy, then idle again
	task automatic t_power_off();
		wait_busy(1'b1, 20);
		host.send_byte(1'b0, PPSC_CMD_POWER_OFF);
		wait_busy(1'b0, 20);
		repeat (2) @(negedge clock_in);
		chk(enables_out[4:0], 5'h00, "drivers off");
		host.send_byte(1'b0, PPSC_CMD_POWER_OFF);
		wait_busy(1'b1, 130);
		chk(enables_out, 6'h00, "all off");
		chk(source_pos_tenths_out, 9'h07e, "config kept");
		chk({common_mode_out == PPSC_OUT_DRIVE, source_mode_out == PPSC_OUT_DRIVE}, 2'b00, "outputs");
		repeat (200) @(negedge clock_in);
		chk(busy_n_out, 1'b1, "refused while busy");
		$display("test power off done");
	endtask
	// main sequence
	initial begin
		clock_in = 1'b0;
		rst_n_in = 1'b0;
		power_on_in = 1'b0;
		display_on_in = 1'b0;
		refreshing_in = 1'b0;
		fail_count = 0;
		num_checks = 0;
		repeat (2) @(negedge clock_in);
		rst_n_in = 1'b1;
		t_defaults();
		t_gate_levels();
		t_full_write();
		t_common();
		t_power_off();
		// mid-run reset must bring every changed setting back to its default
		rst_n_in = 1'b0;
		repeat (2) @(negedge clock_in);
		rst_n_in = 1'b1;
		t_defaults();
		give_verdict();
	end
	// watchdog, far beyond the expected 80 us of traffic
	initial begin
		#500us;
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule
bind ppsc_power_ctrl ppsc_power_ctrl_assertions chk_u (.clock_in, .rst_n_in, .display_on_in, .refreshing_in,
	.busy_n_out, .gate_rail_level_out, .gate_rail_volts_out, .source_pos_tenths_out, .source_neg_tenths_out,
	.fine_step_enable_out, .red_pos_tenths_out, .enables_out, .common_mode_out);
`default_nettype wire
